// ==== rx_liu_pkg.sv ====
package rx_liu_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int ANALOG_LOSS_TIME_US = 1000;
  localparam int ANALOG_LOSS_CYCLES =
    (ANALOG_LOSS_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // -----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -----------------------------------------------------------------
  localparam logic [7:0] TEST_IDX = 8'h1C;
  localparam logic [7:0] CFG_IDX = 8'h20;
  localparam logic [7:0] STAT_IDX = 8'h21;
  localparam logic [7:0] GAIN_IDX = 8'h24;
  localparam logic [7:0] MODE_IDX = 8'h30;
  localparam logic [7:0] LCV_IDX = 8'h31;
  localparam logic [7:0] LOSS_IDX = 8'h32;
  localparam int ADDR_W = 12;

  // -----------------------------------------------------------------
  // field positions and reset values
  // -----------------------------------------------------------------
  localparam int CFG_RST_BIT = 7;
  localparam logic [1:0] CFG_FIXED_BITS = 2'h1;
  localparam logic [1:0] TEST_RST = 2'h0;
  localparam logic [5:0] GAIN_RST = 6'h3F;
  localparam int HOLD_W = 4;
  localparam logic [HOLD_W-1:0] HOLD_RST = 4'h1;
  localparam int RUN_W = 7;
  localparam int LCV_W = 16;

  // -----------------------------------------------------------------
  // zero run limits
  // -----------------------------------------------------------------
  localparam logic [RUN_W-1:0] EXZ_E1 = 7'h0A;
  localparam logic [RUN_W-1:0] EXZ_T1 = 7'h10;
  localparam logic [RUN_W-1:0] EXZ_T1_ZCS = 7'h08;
  localparam logic [RUN_W-1:0] LOS_E1 = 7'h20;
  localparam logic [RUN_W-1:0] LOS_T1 = 7'h64;
  localparam logic [RUN_W-1:0] SUB_ZEROS_E1 = 7'h02;
  localparam logic [RUN_W-1:0] SUB_ZEROS_T1 = 7'h03;

  // bridge compensation gains, Q4 (x1, x3.16, x10, x31.6)
  localparam logic [9:0] BRIDGE_GAIN_0 = 10'h010;
  localparam logic [9:0] BRIDGE_GAIN_1 = 10'h033;
  localparam logic [9:0] BRIDGE_GAIN_2 = 10'h0A0;
  localparam logic [9:0] BRIDGE_GAIN_3 = 10'h1FA;

  // recommended software settings
  localparam logic [7:0] REC_LINE_CFG = 8'h41;
  localparam logic [7:0] REC_RX_TUNING = 8'hB1;
  localparam logic [7:0] REC_SLICER = 8'hBA;
  localparam logic [7:0] REC_EQ_OUTPUT_LEVEL = 8'hDA;
  localparam logic [7:0] REC_PREEQ = 8'hA6;
  localparam logic [7:0] REC_PREEQ_EXT = 8'hE6;
  localparam logic [5:0] REC_GAIN_SHORT = 6'h1D;
  localparam logic [5:0] REC_GAIN_T1 = 6'h21;
  localparam logic [5:0] REC_GAIN_LONG = 6'h34;
  localparam logic [5:0] REC_GAIN_EXT = 6'h3F;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic squelch;
    logic gain_force;
    logic digital_rx_select;
    logic [1:0] bridge_loss_sel;
  } liu_cfg_t;

  typedef struct packed {
    logic [HOLD_W-1:0] error_hold_time;
    logic zeros_to_count_en;
    logic rx_zero_sub_decode;
    logic line_rate_sel;
  } line_mode_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } line_bit_t;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'h0, idx, 2'h0};
  endfunction

  function automatic logic [RUN_W-1:0] exz_limit(input line_mode_t m);
    if (!m.line_rate_sel) begin
      exz_limit = EXZ_E1;
    end else if (m.rx_zero_sub_decode) begin
      exz_limit = EXZ_T1_ZCS;
    end else begin
      exz_limit = EXZ_T1;
    end
  endfunction

  function automatic logic [7:0] bridge_scale(input logic [7:0] coef,
                                              input logic [1:0] sel);
    logic [9:0] g;
    logic [17:0] p;
    g = BRIDGE_GAIN_0;
    unique case (sel)
      2'h0: g = BRIDGE_GAIN_0;
      2'h1: g = BRIDGE_GAIN_1;
      2'h2: g = BRIDGE_GAIN_2;
      2'h3: g = BRIDGE_GAIN_3;
    endcase
    p = coef * g;
    bridge_scale = (p[17:12] != 6'h0) ? 8'hFF : p[11:4];
  endfunction

endpackage

// ==== err_hold_latch.sv ====
`timescale 1ns/1ns
// sticky error flag that holds for a programmable number of bit periods
module err_hold_latch import rx_liu_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic bit_en,
  input wire logic event_in,
  input wire logic [HOLD_W-1:0] hold_len,
  output logic flag
);

  logic flag_ff, nxt_flag;
  logic [HOLD_W-1:0] cnt_ff, nxt_cnt;

  // an event wins over both the clear and the hold expiry
  always_comb begin
    nxt_flag = flag_ff;
    nxt_cnt = cnt_ff;
    if (event_in) begin
      nxt_flag = 1'b1;
      nxt_cnt = hold_len;
    end else if (clr) begin
      nxt_flag = 1'b0;
      nxt_cnt = '0;
    end else if (bit_en && flag_ff) begin
      if (cnt_ff == '0) begin
        nxt_flag = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (ce) begin
      flag_ff <= nxt_flag;
      cnt_ff <= nxt_cnt;
    end
  end

  assign flag = flag_ff;

endmodule

// ==== rx_liu_regs.sv ====
`timescale 1ns/1ns
module rx_liu_regs import rx_liu_pkg::*; #(
  parameter int ANALOG_LOSS_CNT = ANALOG_LOSS_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_LINE_A,
  input wire logic RX_LINE_B,
  input wire logic RX_PLL_BIT_EN,
  input wire logic RX_PLL_LOCKED,
  input wire logic RX_SIGNAL_VALID,
  input wire logic LEVEL_IN_LOSS_RANGE,
  input wire logic EXT_RX_POS_IN,
  input wire logic EXT_RX_NEG_IN,
  input wire logic EXT_RX_CLK_IN,
  input wire logic CLK_ADAPTER_LOCK_ERR_IN,
  input wire logic JITTER_NEAR_EMPTY,
  input wire logic JITTER_NEAR_FULL,
  input wire logic PREEQ_ON_IN,
  input wire logic [7:0] ROM_COEF,
  input wire logic ROM_COEF_VALID,
  output logic RX_DATA_POS,
  output logic RX_DATA_NEG,
  output logic RX_BIT_STROBE,
  output logic LIU_RESET_PULSE,
  output logic ANALOG_RX_BYPASS,
  output logic VGA_FORCE,
  output logic [5:0] VGA_GAIN,
  output logic [7:0] EQ_COEF,
  output logic EQ_COEF_VALID,
  output logic ANALOG_SIGNAL_LOSS,
  output logic SIGNAL_LOSS,
  output logic [1:0] TEST_MODE
);

  localparam int ALOS_W = $clog2(ANALOG_LOSS_CNT + 1);
  localparam logic [ALOS_W-1:0] ALOS_MAX = ALOS_W'(ANALOG_LOSS_CNT);

  // -----------------------------------------------------------------
  // register bank and APB slave
  // -----------------------------------------------------------------
  liu_cfg_t cfg_ff, nxt_cfg;
  line_mode_t mode_ff, nxt_mode;
  logic [1:0] test_ff, nxt_test;
  logic [5:0] gain_ff, nxt_gain;
  logic soft_rst_ff, nxt_soft_rst;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [7:0] status;
  logic wr_en;
  logic hit;

  // line monitor state read back through the bank
  logic jit_limit_ff, nxt_jit_limit;
  logic lock_err_ff, nxt_lock_err;
  logic eq_valid_ff, nxt_eq_valid;
  logic preeq_ff, nxt_preeq;
  logic [LCV_W-1:0] lcv_ff, nxt_lcv;
  logic alos_ff, nxt_alos;
  logic los_ff, nxt_los;
  logic zsub_flag, exz_flag, bpv_flag;

  assign wr_en = PSEL && PENABLE && pready_ff && PWRITE;
  assign status = {lock_err_ff, jit_limit_ff, zsub_flag, exz_flag, bpv_flag,
                   1'b0, eq_valid_ff, preeq_ff};

  // decode, write and read path; no wait states, PREADY is registered from the setup phase
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_mode = mode_ff;
    nxt_test = test_ff;
    nxt_gain = gain_ff;
    nxt_soft_rst = 1'b0;
    nxt_pready = PSEL && !PENABLE && !pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    hit = 1'b1;
    unique case (PADDR)
      reg_addr(TEST_IDX): nxt_prdata = {30'h0, test_ff};
      reg_addr(CFG_IDX): nxt_prdata = {24'h0, 1'b0, cfg_ff, CFG_FIXED_BITS};
      reg_addr(STAT_IDX): nxt_prdata = {24'h0, status};
      reg_addr(GAIN_IDX): nxt_prdata = {26'h0, gain_ff};
      reg_addr(MODE_IDX): nxt_prdata = {24'h0, mode_ff, 1'b0};
      reg_addr(LCV_IDX): nxt_prdata = {16'h0, lcv_ff};
      reg_addr(LOSS_IDX): nxt_prdata = {30'h0, los_ff, alos_ff};
      default: begin
        hit = 1'b0;
        nxt_prdata = 32'h0;
      end
    endcase
    if (nxt_pready) begin
      nxt_pslverr = !hit;
    end
    if (wr_en) begin
      unique case (PADDR)
        reg_addr(TEST_IDX): nxt_test = PWDATA[1:0];
        reg_addr(CFG_IDX): begin
          nxt_cfg = liu_cfg_t'(PWDATA[6:2]);
          nxt_soft_rst = PWDATA[CFG_RST_BIT];
        end
        reg_addr(GAIN_IDX): nxt_gain = PWDATA[5:0];
        reg_addr(MODE_IDX): nxt_mode = line_mode_t'(PWDATA[7:1]);
        default: nxt_soft_rst = 1'b0; // status and counters ignore writes
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cfg_ff <= '0;
      mode_ff <= '{error_hold_time: HOLD_RST, default: 1'b0};
      test_ff <= TEST_RST;
      gain_ff <= GAIN_RST;
      soft_rst_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (CE) begin
      cfg_ff <= nxt_cfg;
      mode_ff <= nxt_mode;
      test_ff <= nxt_test;
      gain_ff <= nxt_gain;
      soft_rst_ff <= nxt_soft_rst;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // -----------------------------------------------------------------
  // receive data path
  // -----------------------------------------------------------------
  logic ext_clk_d_ff, nxt_ext_clk_d;
  line_bit_t bit_ff, nxt_bit;
  logic bit_en_ff, nxt_bit_en;
  line_bit_t out_ff, nxt_out;
  logic strobe_ff, nxt_strobe;
  logic [7:0] coef_ff, nxt_coef;
  logic coef_vld_ff, nxt_coef_vld;

  // input select, squelch and coefficient scaling
  always_comb begin
    nxt_ext_clk_d = EXT_RX_CLK_IN;
    if (cfg_ff.digital_rx_select) begin
      nxt_bit_en = EXT_RX_CLK_IN && !ext_clk_d_ff;
      nxt_bit = '{pos: EXT_RX_POS_IN, neg: EXT_RX_NEG_IN};
    end else begin
      nxt_bit_en = RX_PLL_BIT_EN;
      nxt_bit = '{pos: RX_LINE_A, neg: RX_LINE_B};
    end
    if (!nxt_bit_en) begin
      nxt_bit = bit_ff;
    end
    nxt_strobe = bit_en_ff;
    nxt_out = bit_ff;
    if (cfg_ff.squelch && !eq_valid_ff) begin
      nxt_out = '0;
    end
    nxt_coef = coef_ff;
    nxt_coef_vld = ROM_COEF_VALID;
    if (ROM_COEF_VALID) begin
      nxt_coef = bridge_scale(ROM_COEF, cfg_ff.bridge_loss_sel);
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ext_clk_d_ff <= 1'b0;
      bit_ff <= '0;
      bit_en_ff <= 1'b0;
      out_ff <= '0;
      strobe_ff <= 1'b0;
      coef_ff <= 8'h00;
      coef_vld_ff <= 1'b0;
    end else if (CE) begin
      ext_clk_d_ff <= nxt_ext_clk_d;
      bit_ff <= nxt_bit;
      bit_en_ff <= nxt_bit_en;
      out_ff <= nxt_out;
      strobe_ff <= nxt_strobe;
      coef_ff <= nxt_coef;
      coef_vld_ff <= nxt_coef_vld;
    end
  end

  // -----------------------------------------------------------------
  // line monitors
  // -----------------------------------------------------------------
  logic [RUN_W-1:0] run_ff, nxt_run;
  logic last_pos_ff, nxt_last_pos;
  logic seen_mark_ff, nxt_seen_mark;
  logic [ALOS_W-1:0] alos_cnt_ff, nxt_alos_cnt;
  logic mark, bpv_ev, exz_ev, zsub_ev;
  logic [RUN_W-1:0] run_inc, los_lim, sub_lim;

  assign mark = bit_ff.pos || bit_ff.neg;
  assign run_inc = (run_ff == '1) ? run_ff : run_ff + 1'b1;
  assign los_lim = mode_ff.line_rate_sel ? LOS_T1 : LOS_E1;
  assign sub_lim = mode_ff.line_rate_sel ? SUB_ZEROS_T1 : SUB_ZEROS_E1;
  // a mark of the same polarity as the previous mark
  assign bpv_ev = bit_en_ff && mark && seen_mark_ff && (bit_ff.pos == last_pos_ff);
  assign exz_ev = bit_en_ff && !mark && (run_inc == exz_limit(mode_ff));
  // substitution codes place their violation after a fixed zero run
  assign zsub_ev = bpv_ev && (run_ff >= sub_lim);

  // run counters, loss detection, status capture and violation count
  always_comb begin
    nxt_run = run_ff;
    nxt_last_pos = last_pos_ff;
    nxt_seen_mark = seen_mark_ff;
    if (bit_en_ff) begin
      nxt_run = mark ? '0 : run_inc;
      if (mark) begin
        nxt_last_pos = bit_ff.pos;
        nxt_seen_mark = 1'b1;
      end
    end
    nxt_alos_cnt = '0;
    if (LEVEL_IN_LOSS_RANGE) begin
      nxt_alos_cnt = (alos_cnt_ff == ALOS_MAX) ? alos_cnt_ff : alos_cnt_ff + 1'b1;
    end
    if (soft_rst_ff) begin
      nxt_run = '0;
      nxt_seen_mark = 1'b0;
      nxt_alos_cnt = '0;
    end
    nxt_alos = (nxt_alos_cnt == ALOS_MAX);
    nxt_los = (nxt_run >= los_lim);
    nxt_jit_limit = jit_limit_ff;
    if (JITTER_NEAR_EMPTY) begin
      nxt_jit_limit = 1'b1;
    end else if (JITTER_NEAR_FULL) begin
      nxt_jit_limit = 1'b0;
    end
    nxt_lock_err = CLK_ADAPTER_LOCK_ERR_IN;
    nxt_eq_valid = RX_SIGNAL_VALID && RX_PLL_LOCKED;
    nxt_preeq = PREEQ_ON_IN;
    nxt_lcv = lcv_ff;
    if ((bpv_ev || (exz_ev && mode_ff.zeros_to_count_en)) && lcv_ff != '1) begin
      nxt_lcv = lcv_ff + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      run_ff <= '0;
      last_pos_ff <= 1'b0;
      seen_mark_ff <= 1'b0;
      alos_cnt_ff <= '0;
      alos_ff <= 1'b0;
      los_ff <= 1'b0;
      jit_limit_ff <= 1'b0;
      lock_err_ff <= 1'b0;
      eq_valid_ff <= 1'b0;
      preeq_ff <= 1'b0;
      lcv_ff <= '0;
    end else if (CE) begin
      run_ff <= nxt_run;
      last_pos_ff <= nxt_last_pos;
      seen_mark_ff <= nxt_seen_mark;
      alos_cnt_ff <= nxt_alos_cnt;
      alos_ff <= nxt_alos;
      los_ff <= nxt_los;
      jit_limit_ff <= nxt_jit_limit;
      lock_err_ff <= nxt_lock_err;
      eq_valid_ff <= nxt_eq_valid;
      preeq_ff <= nxt_preeq;
      lcv_ff <= nxt_lcv;
    end
  end

  // sticky flags with programmable hold
  err_hold_latch u_zsub (.clk(REF_CLK), .rst(RESET), .ce(CE), .clr(soft_rst_ff),
    .bit_en(bit_en_ff), .event_in(zsub_ev), .hold_len(mode_ff.error_hold_time),
    .flag(zsub_flag));
  err_hold_latch u_exz (.clk(REF_CLK), .rst(RESET), .ce(CE), .clr(soft_rst_ff),
    .bit_en(bit_en_ff), .event_in(exz_ev), .hold_len(mode_ff.error_hold_time),
    .flag(exz_flag));
  err_hold_latch u_bpv (.clk(REF_CLK), .rst(RESET), .ce(CE), .clr(soft_rst_ff),
    .bit_en(bit_en_ff), .event_in(bpv_ev), .hold_len(mode_ff.error_hold_time),
    .flag(bpv_flag));

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign RX_DATA_POS = out_ff.pos;
  assign RX_DATA_NEG = out_ff.neg;
  assign RX_BIT_STROBE = strobe_ff;
  assign LIU_RESET_PULSE = soft_rst_ff;
  assign ANALOG_RX_BYPASS = cfg_ff.digital_rx_select;
  assign VGA_FORCE = cfg_ff.gain_force;
  assign VGA_GAIN = gain_ff;
  assign EQ_COEF = coef_ff;
  assign EQ_COEF_VALID = coef_vld_ff;
  assign ANALOG_SIGNAL_LOSS = alos_ff;
  assign SIGNAL_LOSS = los_ff;
  assign TEST_MODE = test_ff;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence cfg_write_rst;
    CE && wr_en && PADDR == reg_addr(CFG_IDX) && PWDATA[CFG_RST_BIT];
  endsequence
  sequence one_pulse;
    LIU_RESET_PULSE ##1 (!LIU_RESET_PULSE || !CE || wr_en);
  endsequence

  soft_reset_pulse_a: assert property (cfg_write_rst |=> one_pulse)
    else $error("soft reset did not pulse for one cycle");
  cfg_readback_a: assert property (CE && nxt_pready && PADDR == reg_addr(CFG_IDX)
    |=> PRDATA[CFG_RST_BIT] == 1'b0 && PRDATA[1:0] == 2'h1)
    else $error("config readback shows reset bit or wrong fixed bits");
  squelch_hold_a: assert property (CE && cfg_ff.squelch && !eq_valid_ff
    |=> !RX_DATA_POS && !RX_DATA_NEG)
    else $error("squelched data not zero");
  status_ro_a: assert property (CE && wr_en && PADDR == reg_addr(STAT_IDX)
    |=> $stable(cfg_ff) && $stable(gain_ff))
    else $error("status write changed configuration");
  jitter_hold_a: assert property (CE && !JITTER_NEAR_EMPTY && !JITTER_NEAR_FULL
    |=> $stable(jit_limit_ff))
    else $error("jitter limit changed away from a limit");
  viol_count_a: assert property (CE && bpv_ev && lcv_ff != '1
    |=> lcv_ff == $past(lcv_ff) + 1'b1 ##0 bpv_flag)
    else $error("violation not counted or latched");
  exz_latch_a: assert property (CE && exz_ev |=> exz_flag)
    else $error("excess zeros flag not latched");
  signal_loss_a: assert property (CE && !soft_rst_ff && bit_en_ff && !mark
    && run_inc >= los_lim |=> SIGNAL_LOSS)
    else $error("signal loss not declared after zero run");
  analog_loss_a: assert property (CE && LEVEL_IN_LOSS_RANGE && alos_cnt_ff == ALOS_MAX - 1'b1
    && !soft_rst_ff |=> ANALOG_SIGNAL_LOSS)
    else $error("analog loss not declared on time");
  eq_valid_a: assert property (CE |=> eq_valid_ff == $past(RX_SIGNAL_VALID && RX_PLL_LOCKED))
    else $error("eq valid does not follow signal and lock");

endmodule

// ==== line_src.sv ====
`timescale 1ns/1ns
// bipolar line source standing in for the analog receiver and its PLL
module line_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic mark,
  input wire logic bipolar_violation_flag,
  output logic line_a,
  output logic line_b,
  output logic bit_en
);
  logic last_pos_ff;
  logic pos;
  // marks alternate polarity unless a violation repeats the last one
  assign pos = bipolar_violation_flag ? last_pos_ff : !last_pos_ff;
  // one bit per request; lines toggle between bits so stale levels never pass as data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_pos_ff <= 1'b0;
      line_a <= 1'b0;
      line_b <= 1'b0;
      bit_en <= 1'b0;
    end else if (req) begin
      bit_en <= 1'b1;
      line_a <= mark & pos;
      line_b <= mark & !pos;
      if (mark) last_pos_ff <= pos;
    end else begin
      bit_en <= 1'b0;
      line_a <= !line_a;
      line_b <= !line_b;
    end
  end
endmodule

// ==== test_rx_line_iface_ctrl_status.sv ====
`timescale 1ns/1ns
module test_rx_line_iface_ctrl_status import rx_liu_pkg::*; ;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr, req, mark, bipolar_violation_flag;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic line_a, line_b, bit_en, locked, sig_ok, level, lock_err, near_empty, near_full;
  logic preeq, rom_v, strobe, dpos, dneg, rpulse, bypass, vga_force, eq_v, aloss, sloss;
  logic [5:0] vga_gain;
  logic [7:0] rom_coef, eq_coef;
  logic [1:0] test_mode, sdat;
  logic [9:0] gn [4];
  logic [7:0] md [3];
  logic [RUN_W-1:0] ex [3];
  logic [RUN_W-1:0] ls [3];
  logic [17:0] e;
  int err_count, tests_run, i, j;

  line_src i_line (.clk(clk), .rst(rst), .req(req), .mark(mark), .bipolar_violation_flag(bipolar_violation_flag),
    .line_a(line_a), .line_b(line_b), .bit_en(bit_en));

  rx_liu_regs #(.ANALOG_LOSS_CNT(20)) i_dut (.REF_CLK(clk), .RESET(rst), .CE(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_LINE_A(line_a),
    .RX_LINE_B(line_b), .RX_PLL_BIT_EN(bit_en), .RX_PLL_LOCKED(locked),
    .RX_SIGNAL_VALID(sig_ok), .LEVEL_IN_LOSS_RANGE(level), .EXT_RX_POS_IN(1'b0),
    .EXT_RX_NEG_IN(1'b0), .EXT_RX_CLK_IN(1'b0), .CLK_ADAPTER_LOCK_ERR_IN(lock_err),
    .JITTER_NEAR_EMPTY(near_empty), .JITTER_NEAR_FULL(near_full), .PREEQ_ON_IN(preeq),
    .ROM_COEF(rom_coef), .ROM_COEF_VALID(rom_v), .RX_DATA_POS(dpos), .RX_DATA_NEG(dneg),
    .RX_BIT_STROBE(strobe), .LIU_RESET_PULSE(rpulse), .ANALOG_RX_BYPASS(bypass),
    .VGA_FORCE(vga_force), .VGA_GAIN(vga_gain), .EQ_COEF(eq_coef), .EQ_COEF_VALID(eq_v),
    .ANALOG_SIGNAL_LOSS(aloss), .SIGNAL_LOSS(sloss), .TEST_MODE(test_mode));

  // clock generator
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------
  // bus and line tasks
  // ----------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "bus hang");
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] msk, input logic [31:0] exp);
    acc(1'b0, idx, 32'h0);
    chk(rdat & msk, exp, "register read");
  endtask

  task automatic sreset(input logic [7:0] cfg);
    int n;
    acc(1'b1, CFG_IDX, {24'h0, cfg | 8'h80});
    #1;
    n = 0;
    while (rpulse !== 1'b1 && n < 5) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, rpulse}, 32'h1, "reset pulse");
    @(posedge clk);
    #1;
    chk({31'h0, rpulse}, 32'h0, "reset pulse width");
  endtask

  task automatic bit_tx(input logic m, input logic v);
    int n;
    @(posedge clk);
    req <= 1'b1;
    mark <= m;
    bipolar_violation_flag <= v;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (strobe !== 1'b1 && n < 8);
    sdat = {dpos, dneg};
    if (n >= 8) chk(32'h0, 32'h1, "no bit strobe");
  endtask

  task automatic zeros(input int k);
    repeat (k) bit_tx(1'b0, 1'b0);
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    chk(32'h0, 32'h1, "watchdog");
    give_verdict();
  end

  // ----------------------------
  // tests
  // ----------------------------
  initial begin
    gn = '{BRIDGE_GAIN_0, BRIDGE_GAIN_1, BRIDGE_GAIN_2, BRIDGE_GAIN_3};
    md = '{8'hF8, 8'hFA, 8'hFE};
    ex = '{EXZ_E1, EXZ_T1, EXZ_T1_ZCS};
    ls = '{LOS_E1, LOS_T1, LOS_T1};
    {psel, penable, pwrite, req, mark, bipolar_violation_flag, locked, sig_ok, level} = '0;
    {lock_err, near_empty, near_full, preeq, rom_v} = '0;
    paddr = '0;
    pwdata = '0;
    rom_coef = '0;
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(CFG_IDX, 32'hFF, 32'h01);
    rd(GAIN_IDX, 32'hFF, 32'h3F);
    rd(STAT_IDX, 32'hFF, 32'h00);
    acc(1'b0, 8'h3F, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    chk(rdat, 32'h0, "unmapped data");
    acc(1'b1, CFG_IDX, 32'hFE);
    rd(CFG_IDX, 32'hFF, 32'h7D);
    chk({30'h0, vga_force, bypass}, 32'h3, "gain force and bypass");
    acc(1'b1, GAIN_IDX, 32'h1D);
    rd(GAIN_IDX, 32'hFF, 32'h1D);
    chk({26'h0, vga_gain}, 32'h1D, "forced gain");
    acc(1'b1, TEST_IDX, 32'hFF);
    rd(TEST_IDX, 32'hFF, 32'h03);
    chk({30'h0, test_mode}, 32'h3, "test mode");
    for (i = 0; i < 4; i++) begin
      sreset(8'(i << 2) | 8'h01);
      @(posedge clk);
      rom_coef <= 8'h08;
      rom_v <= 1'b1;
      @(posedge clk);
      rom_v <= 1'b0;
      #1;
      j = 0;
      while (eq_v !== 1'b1 && j < 5) begin
        @(posedge clk);
        #1;
        j++;
      end
      chk({31'h0, eq_v}, 32'h1, "coefficient strobe");
      e = (18'(gn[i]) * 18'h8) >> 4;
      chk({24'h0, eq_coef}, {24'h0, e[7:0]}, "bridge scaling");
    end
    lock_err <= 1'b1;
    preeq <= 1'b1;
    near_empty <= 1'b1;
    rd(STAT_IDX, 32'hC1, 32'hC1);
    near_empty <= 1'b0;
    rd(STAT_IDX, 32'h40, 32'h40);
    near_full <= 1'b1;
    acc(1'b1, STAT_IDX, 32'hFF);
    rd(STAT_IDX, 32'hC3, 32'h81);
    {lock_err, near_full} <= 2'h0;
    acc(1'b1, CFG_IDX, 32'h41);
    bit_tx(1'b1, 1'b0);
    chk({30'h0, sdat}, 32'h0, "squelched data");
    {locked, sig_ok} <= 2'h3;
    rd(STAT_IDX, 32'h02, 32'h02);
    bit_tx(1'b1, 1'b0);
    chk({31'h0, ^sdat}, 32'h1, "unsquelched mark");
    level <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk({31'h0, aloss}, 32'h0, "early analog loss");
    repeat (15) @(posedge clk);
    #1;
    chk({31'h0, aloss}, 32'h1, "analog loss");
    level <= 1'b0;
    for (i = 0; i < 3; i++) begin
      acc(1'b1, MODE_IDX, {24'h0, md[i]});
      sreset(8'h01);
      bit_tx(1'b1, 1'b0);
      zeros(int'(ex[i]) - 1);
      rd(STAT_IDX, 32'h10, 32'h00);
      zeros(1);
      rd(STAT_IDX, 32'h10, 32'h10);
      rd(LCV_IDX, 32'hFFFF, i + 1);
      zeros(int'(ls[i]) - int'(ex[i]) - 1);
      @(posedge clk);
      #1;
      chk({31'h0, sloss}, 32'h0, "early signal loss");
      zeros(1);
      @(posedge clk);
      #1;
      chk({31'h0, sloss}, 32'h1, "signal loss");
    end
    acc(1'b1, MODE_IDX, 32'hF8);
    sreset(8'h01);
    bit_tx(1'b1, 1'b0);
    zeros(2);
    bit_tx(1'b1, 1'b1);
    rd(STAT_IDX, 32'h38, 32'h28);
    rd(LCV_IDX, 32'hFFFF, 32'h4);
    give_verdict();
  end
endmodule
